// [rtl/shp_pkg.sv]
package shp_pkg;
	// register byte addresses (word aligned)
	localparam logic [31:0] ADDR_PRIO_A = 32'hE000ED18;
	localparam logic [31:0] ADDR_PRIO_B = 32'hE000ED1C;
	localparam logic [31:0] ADDR_PRIO_C = 32'hE000ED20;
	localparam logic [31:0] ADDR_CTRL = 32'hE000ED24;
	localparam logic [31:0] ADDR_IRQ_STATUS = 32'hE000ED28;
	localparam logic [31:0] ADDR_IRQ_MASK = 32'hE000ED2C;
	// priority byte layout
	localparam int PRIO_BITS = 3;
	localparam int BYTE_BITS = 8;
	localparam int PRIO_LSB = 5;
	localparam int PRIO_SLOTS = 12;
	localparam logic [31:0] PRIO_RESET = 32'h00000000;
	// control/state word fields
	localparam int BIT_USG_ENA = 18;
	localparam int BIT_BUS_ENA = 17;
	localparam int BIT_MEM_ENA = 16;
	localparam int BIT_SVC_PEND = 15;
	localparam int BIT_BUS_PEND = 14;
	localparam int BIT_MEM_PEND = 13;
	localparam int BIT_USG_PEND = 12;
	localparam int BIT_TICK_ACT = 11;
	localparam int BIT_PSV_ACT = 10;
	localparam int BIT_MON_ACT = 8;
	localparam int BIT_SVC_ACT = 7;
	localparam int BIT_USG_ACT = 3;
	localparam int BIT_BUS_ACT = 1;
	localparam int BIT_MEM_ACT = 0;
	localparam logic [31:0] CTRL_WMASK = 32'h0007FD8B;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	// handler indices on the entry/return/pend vectors
	localparam int H_MEM = 0;
	localparam int H_BUS = 1;
	localparam int H_USG = 2;
	localparam int H_SVC = 3;
	localparam int H_MON = 4;
	localparam int H_PSV = 5;
	localparam int H_TICK = 6;
	localparam int N_HANDLERS = 7;
	// interrupt status: bit0 entry, bit1 pend set
	localparam int N_IRQ = 2;
	localparam logic [31:0] DATA_ZERO = 32'h00000000;
endpackage : shp_pkg

// [rtl/system_handler_priority_state.sv]
// Contract
// - one eight-bit priority byte per exception
// - only top three bits hold state
// - unimplemented priority bits read zero, ignore writes
// - usage fault priority at bits 23-21
// - bus fault priority at bits 15-13
// - memory fault priority at bits 7-5
// - three words map handlers 4 to 15
// - bits 31-29 word a reserved storage
// - fault enables and pending flags layout
// - active flags layout, zero reset
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module system_handler_priority_state
	import shp_pkg::*;
(
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// avalon-mm slave
	input wire logic [31:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// exception unit events, one bit per handler index
	input wire logic [N_HANDLERS-1:0] exc_entry,
	input wire logic [N_HANDLERS-1:0] exc_return,
	input wire logic [N_HANDLERS-1:0] exc_pend_req,
	// to arbitration
	output logic [PRIO_SLOTS*PRIO_BITS-1:0] handler_priority,
	output logic usage_fault_enable,
	output logic bus_fault_enable,
	output logic mem_manage_enable,
	output logic [31:0] control_state,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_DONE = 3'b010,
		BUS_SPARE = 3'b100
	} bus_state_t;

	bus_state_t bus_r, bus_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [PRIO_SLOTS*PRIO_BITS-1:0] prio_r, prio_nxt;
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [N_IRQ-1:0] ists_r, ists_nxt, imask_r, imask_nxt;
	logic irq_nxt;
	logic [31:0] bmask;
	logic wr_go, rd_go;
	logic [31:0] prio_word [3];
	logic [N_HANDLERS-1:0] act_vec, pend_hw;

	// one access per two cycles: wait, then answer
	// waitrequest idles high, so a request is never answered in the cycle it appears
	assign wr_go = (bus_r == BUS_IDLE) && avs_write;
	assign rd_go = (bus_r == BUS_IDLE) && avs_read && !avs_write;
	assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	////////////////////////////////////////////////////////////////////////
	// priority words: 12 slots, three bits each
	genvar g;
	generate
		for (g = 0; g < PRIO_SLOTS; g++) begin : g_slot
			assign prio_word[g/4][(g%4)*BYTE_BITS +: BYTE_BITS] =
				{prio_r[g*PRIO_BITS +: PRIO_BITS], {PRIO_LSB{1'b0}}};
		end
	endgenerate

	always_comb begin
		logic [31:0] w;
		logic [1:0] idx;
		w = avs_writedata & bmask;
		idx = 2'h0;
		prio_nxt = prio_r;
		case (avs_address)
			ADDR_PRIO_A: idx = 2'h0;
			ADDR_PRIO_B: idx = 2'h1;
			default: idx = 2'h2;
		endcase
		// lane-gated, so a narrow store leaves the neighbouring bytes alone
		if (wr_go && (avs_address == ADDR_PRIO_A || avs_address == ADDR_PRIO_B ||
			avs_address == ADDR_PRIO_C)) begin
			for (int k = 0; k < 4; k++) begin
				if (avs_byteenable[k]) begin
					prio_nxt[(idx*4+k)*PRIO_BITS +: PRIO_BITS] =
						w[k*BYTE_BITS+PRIO_LSB +: PRIO_BITS];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control and state word
	assign act_vec = {ctrl_r[BIT_TICK_ACT], ctrl_r[BIT_PSV_ACT], ctrl_r[BIT_MON_ACT],
		ctrl_r[BIT_SVC_ACT], ctrl_r[BIT_USG_ACT], ctrl_r[BIT_BUS_ACT], ctrl_r[BIT_MEM_ACT]};
	// pend on a request unless that handler enters in the same cycle while not already active
	assign pend_hw = exc_pend_req & (act_vec | ~exc_entry);

	always_comb begin
		logic [31:0] c;
		logic [31:0] wm;
		c = ctrl_r;
		wm = CTRL_WMASK & bmask;
		// enables and pends, active flags; software edits
		if (wr_go && avs_address == ADDR_CTRL) begin
			c = (c & ~wm) | (avs_writedata & wm);
		end
		// hardware events are applied after the store, so they win over software
		// return clears active, entry sets it; set wins
		c[BIT_MEM_ACT] = (c[BIT_MEM_ACT] & ~exc_return[H_MEM]) | exc_entry[H_MEM];
		c[BIT_BUS_ACT] = (c[BIT_BUS_ACT] & ~exc_return[H_BUS]) | exc_entry[H_BUS];
		c[BIT_USG_ACT] = (c[BIT_USG_ACT] & ~exc_return[H_USG]) | exc_entry[H_USG];
		c[BIT_SVC_ACT] = (c[BIT_SVC_ACT] & ~exc_return[H_SVC]) | exc_entry[H_SVC];
		c[BIT_MON_ACT] = (c[BIT_MON_ACT] & ~exc_return[H_MON]) | exc_entry[H_MON];
		c[BIT_PSV_ACT] = (c[BIT_PSV_ACT] & ~exc_return[H_PSV]) | exc_entry[H_PSV];
		c[BIT_TICK_ACT] = (c[BIT_TICK_ACT] & ~exc_return[H_TICK]) | exc_entry[H_TICK];
		// pend set on blocked request; entry clears it
		c[BIT_MEM_PEND] = (c[BIT_MEM_PEND] & ~exc_entry[H_MEM]) | pend_hw[H_MEM];
		c[BIT_BUS_PEND] = (c[BIT_BUS_PEND] & ~exc_entry[H_BUS]) | pend_hw[H_BUS];
		c[BIT_USG_PEND] = (c[BIT_USG_PEND] & ~exc_entry[H_USG]) | pend_hw[H_USG];
		c[BIT_SVC_PEND] = (c[BIT_SVC_PEND] & ~exc_entry[H_SVC]) | pend_hw[H_SVC];
		ctrl_nxt = c & CTRL_WMASK;
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt status (write one to clear, event wins) and mask
	always_comb begin
		logic [N_IRQ-1:0] ev;
		ev = {|pend_hw, |exc_entry};
		// irq is a level: clearing status drops it one cycle after the write
		ists_nxt = ists_r;
		imask_nxt = imask_r;
		if (wr_go && avs_address == ADDR_IRQ_STATUS && avs_byteenable[0]) begin
			ists_nxt = ists_r & ~avs_writedata[N_IRQ-1:0];
		end
		if (wr_go && avs_address == ADDR_IRQ_MASK && avs_byteenable[0]) begin
			imask_nxt = avs_writedata[N_IRQ-1:0];
		end
		ists_nxt = ists_nxt | ev;
		irq_nxt = |(ists_nxt & imask_nxt);
	end

	////////////////////////////////////////////////////////////////////////
	// bus handshake and read mux
	always_comb begin
		bus_nxt = bus_r;
		rdata_nxt = rdata_r;
		case (bus_r)
			BUS_IDLE: begin
				if (wr_go || rd_go) begin
					bus_nxt = BUS_DONE;
				end
				if (rd_go) begin
					case (avs_address)
						ADDR_PRIO_A: rdata_nxt = prio_word[0];
						ADDR_PRIO_B: rdata_nxt = prio_word[1];
						ADDR_PRIO_C: rdata_nxt = prio_word[2];
						ADDR_CTRL: rdata_nxt = ctrl_r;
						ADDR_IRQ_STATUS: rdata_nxt = {{(32-N_IRQ){1'b0}}, ists_r};
						ADDR_IRQ_MASK: rdata_nxt = {{(32-N_IRQ){1'b0}}, imask_r};
						default: rdata_nxt = DATA_ZERO;
					endcase
				end
			end
			BUS_DONE: bus_nxt = BUS_IDLE;
			default: bus_nxt = BUS_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_r <= BUS_IDLE;
			rdata_r <= DATA_ZERO;
			prio_r <= '0;
			ctrl_r <= CTRL_RESET;
			ists_r <= '0;
			imask_r <= '0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= DATA_ZERO;
			handler_priority <= '0;
			usage_fault_enable <= 1'b0;
			bus_fault_enable <= 1'b0;
			mem_manage_enable <= 1'b0;
			control_state <= DATA_ZERO;
			irq <= 1'b0;
		end else if (clk_en) begin
			bus_r <= bus_nxt;
			rdata_r <= rdata_nxt;
			prio_r <= prio_nxt;
			ctrl_r <= ctrl_nxt;
			ists_r <= ists_nxt;
			imask_r <= imask_nxt;
			avs_waitrequest <= !(bus_nxt == BUS_DONE);
			avs_readdata <= rdata_nxt;
			handler_priority <= prio_nxt;
			usage_fault_enable <= ctrl_nxt[BIT_USG_ENA];
			bus_fault_enable <= ctrl_nxt[BIT_BUS_ENA];
			mem_manage_enable <= ctrl_nxt[BIT_MEM_ENA];
			control_state <= ctrl_nxt;
			irq <= irq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// priority storage and read-back
	chk_prio_low_zero: assert property (avs_read && !avs_waitrequest &&
		$past(avs_address) == ADDR_PRIO_A |-> avs_readdata[28:24] == 5'h00 &&
		avs_readdata[20:16] == 5'h00 && avs_readdata[12:8] == 5'h00 &&
		avs_readdata[4:0] == 5'h00)
		else $error("priority low bits not zero");
	chk_prio_bc_zero: assert property (avs_read && !avs_waitrequest &&
		($past(avs_address) == ADDR_PRIO_B || $past(avs_address) == ADDR_PRIO_C) |->
		(avs_readdata & 32'h1F1F1F1F) == DATA_ZERO)
		else $error("priority low bits not zero in upper words");
	chk_usage_prio_wr: assert property (clk_en && wr_go && avs_address == ADDR_PRIO_A &&
		avs_byteenable[2] |=> handler_priority[8:6] == $past(avs_writedata[23:21]))
		else $error("usage fault priority not stored");
	chk_bus_prio_wr: assert property (clk_en && wr_go && avs_address == ADDR_PRIO_A &&
		avs_byteenable[1] |=> handler_priority[5:3] == $past(avs_writedata[15:13]))
		else $error("bus fault priority not stored");
	chk_mem_prio_wr: assert property (clk_en && wr_go && avs_address == ADDR_PRIO_A &&
		avs_byteenable[0] |=> handler_priority[2:0] == $past(avs_writedata[7:5]))
		else $error("mem fault priority not stored");
	chk_word_a_rsvd: assert property (clk_en && wr_go && avs_address == ADDR_PRIO_A &&
		avs_byteenable[3] |=> handler_priority[11:9] == $past(avs_writedata[31:29]))
		else $error("reserved priority slot not stored");
	chk_svc_prio_wr: assert property (clk_en && wr_go && avs_address == ADDR_PRIO_B &&
		avs_byteenable[3] |=> handler_priority[23:21] == $past(avs_writedata[31:29]))
		else $error("supervisor call priority not stored");
	chk_mon_prio_wr: assert property (clk_en && wr_go && avs_address == ADDR_PRIO_C &&
		avs_byteenable[0] |=> handler_priority[26:24] == $past(avs_writedata[7:5]))
		else $error("debug monitor priority not stored");
	chk_psv_prio_wr: assert property (clk_en && wr_go && avs_address == ADDR_PRIO_C &&
		avs_byteenable[2] |=> handler_priority[32:30] == $past(avs_writedata[23:21]))
		else $error("pendable service priority not stored");
	chk_tick_prio_wr: assert property (clk_en && wr_go && avs_address == ADDR_PRIO_C &&
		avs_byteenable[3] |=> handler_priority[35:33] == $past(avs_writedata[31:29]))
		else $error("tick priority not stored");
	chk_prio_lane_off: assert property (clk_en && wr_go && avs_address == ADDR_PRIO_A &&
		!avs_byteenable[2] |=> $stable(handler_priority[8:6]))
		else $error("disabled lane changed a priority");

	// control word and event flags
	chk_ctrl_zero_bits: assert property (control_state[31:19] == 13'h0000 &&
		control_state[9] == 1'b0 && control_state[6:4] == 3'h0 && control_state[2] == 1'b0)
		else $error("reserved control bits set");
	chk_enable_copy: assert property (usage_fault_enable == control_state[BIT_USG_ENA] &&
		bus_fault_enable == control_state[BIT_BUS_ENA] && mem_manage_enable == control_state[BIT_MEM_ENA])
		else $error("fault enable outputs disagree with control word");
	chk_enable_wr: assert property (clk_en && wr_go && avs_address == ADDR_CTRL &&
		avs_byteenable[2] |=> usage_fault_enable == $past(avs_writedata[BIT_USG_ENA]))
		else $error("usage fault enable not stored");
	chk_ctrl_act_wr: assert property (clk_en && wr_go && avs_address == ADDR_CTRL &&
		avs_byteenable[1] && exc_entry == '0 && exc_return == '0 |=>
		control_state[BIT_TICK_ACT] == $past(avs_writedata[BIT_TICK_ACT]))
		else $error("active flag not stored by software");
	chk_entry_active: assert property (clk_en && exc_entry[H_SVC] |=> control_state[BIT_SVC_ACT])
		else $error("entry did not set active");
	chk_return_clear: assert property (clk_en && exc_return[H_TICK] && !exc_entry[H_TICK] &&
		!(wr_go && avs_address == ADDR_CTRL) |=> !control_state[BIT_TICK_ACT])
		else $error("return did not clear active");
	chk_pend_set: assert property (clk_en && exc_pend_req[H_BUS] && !exc_entry[H_BUS] |=>
		control_state[BIT_BUS_PEND])
		else $error("blocked request did not set pending");
	chk_entry_unpend: assert property (clk_en && exc_entry[H_MEM] && !exc_pend_req[H_MEM] &&
		!(wr_go && avs_address == ADDR_CTRL) |=> !control_state[BIT_MEM_PEND])
		else $error("entry did not clear pending");

	// interrupt, clock enable and bus timing
	chk_status_clear: assert property (clk_en && wr_go && avs_address == ADDR_IRQ_STATUS &&
		avs_byteenable[0] && avs_writedata[0] && exc_entry == '0 |=> !ists_r[0])
		else $error("status bit not cleared by write of one");
	chk_mask_store: assert property (clk_en && wr_go && avs_address == ADDR_IRQ_MASK &&
		avs_byteenable[0] |=> imask_r == $past(avs_writedata[N_IRQ-1:0]))
		else $error("interrupt mask not stored");
	chk_irq_level: assert property (irq == |(ists_r & imask_r))
		else $error("interrupt level disagrees with status and mask");
	chk_clock_freeze: assert property (!clk_en |=> $stable(control_state) && $stable(handler_priority) &&
		$stable(irq) && $stable(avs_waitrequest))
		else $error("state moved while clock enable low");
	chk_bus_answer: assert property (clk_en && (wr_go || rd_go) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing wrong");

	cov_entry: cover property (exc_entry[H_USG]);
	cov_pend: cover property (exc_pend_req[H_BUS] && control_state[BIT_BUS_ACT]);
	cov_irq: cover property (irq);
	cov_ctrl_wr: cover property (wr_go && avs_address == ADDR_CTRL);
	cov_freeze: cover property (!clk_en && exc_return != '0);

endmodule : system_handler_priority_state
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb import shp_pkg::*;;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [31:0] avs_address = 32'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [N_HANDLERS-1:0] exc_entry = '0;
	logic [N_HANDLERS-1:0] exc_return = '0;
	logic [N_HANDLERS-1:0] exc_pend_req = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [PRIO_SLOTS*PRIO_BITS-1:0] handler_priority;
	logic usage_fault_enable;
	logic bus_fault_enable;
	logic mem_manage_enable;
	logic [31:0] control_state;
	logic irq;
	int bad_count = 0;
	int n_checks = 0;
	logic [31:0] m_prio [3] = '{32'h0, 32'h0, 32'h0};
	logic [31:0] m_ctrl = 32'h0;
	logic [31:0] m_stat = 32'h0;
	logic [31:0] m_mask = 32'h0;
	int act_bit [7] = '{0, 1, 3, 7, 8, 10, 11};
	int pend_bit [4] = '{13, 14, 12, 15};
	logic [31:0] rd;
	always #5 ref_clk = ~ref_clk;
	system_handler_priority_state dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.exc_entry(exc_entry), .exc_return(exc_return), .exc_pend_req(exc_pend_req),
		.handler_priority(handler_priority), .usage_fault_enable(usage_fault_enable),
		.bus_fault_enable(bus_fault_enable), .mem_manage_enable(mem_manage_enable),
		.control_state(control_state), .irq(irq));
	////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (bad_count == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : final_report
	task automatic check(input logic [35:0] got, input logic [35:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	// master holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] data, input logic [3:0] be);
		int i;
		@(posedge ref_clk);
		avs_address <= addr;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= data;
		avs_byteenable <= be;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		if (i == 20) begin
			bad_count++;
			$display("unexpected at %0t: bus hang", $time);
			final_report();
		end else begin
			rd = avs_readdata;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
		end
	endtask : bus
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] model_read(input logic [31:0] a);
		if (a == ADDR_PRIO_A || a == ADDR_PRIO_B || a == ADDR_PRIO_C) return m_prio[(a - ADDR_PRIO_A) >> 2];
		if (a == ADDR_CTRL) return m_ctrl;
		if (a == ADDR_IRQ_STATUS) return m_stat;
		if (a == ADDR_IRQ_MASK) return m_mask;
		return 32'h0;
	endfunction : model_read
	task automatic compare_all();
		logic [35:0] ep;
		for (int s = 0; s < 12; s++) ep[3*s+:3] = m_prio[s/4][8*(s%4)+5+:3];
		check(handler_priority, ep);
		check(36'(control_state), 36'(m_ctrl));
		check(36'({usage_fault_enable, bus_fault_enable, mem_manage_enable}), 36'(m_ctrl[18:16]));
		check(36'(irq), 36'(|(m_stat & m_mask)));
	endtask : compare_all
	task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] lm;
		for (int k = 0; k < 4; k++) lm[8*k+:8] = {8{be[k]}};
		bus(1'b1, a, d, be);
		if (a == ADDR_PRIO_A || a == ADDR_PRIO_B || a == ADDR_PRIO_C)
			m_prio[(a - ADDR_PRIO_A) >> 2] = (m_prio[(a - ADDR_PRIO_A) >> 2] & ~lm) | (d & lm & 32'hE0E0E0E0);
		if (a == ADDR_CTRL) m_ctrl = (m_ctrl & ~(lm & CTRL_WMASK)) | (d & lm & CTRL_WMASK);
		if (a == ADDR_IRQ_STATUS && be[0]) m_stat = m_stat & ~(d & 32'h3);
		if (a == ADDR_IRQ_MASK && be[0]) m_mask = d & 32'h3;
		bus(1'b0, a, 32'h0, 4'hF);
		check(36'(rd), 36'(model_read(a)));
		compare_all();
	endtask : wr_rd
	// kind 0 entry, 1 return, 2 pend request
	task automatic ev(input int kind, input int h);
		@(posedge ref_clk);
		if (kind == 0) exc_entry[h] <= 1'b1;
		if (kind == 1) exc_return[h] <= 1'b1;
		if (kind == 2) exc_pend_req[h] <= 1'b1;
		@(posedge ref_clk);
		exc_entry <= '0;
		exc_return <= '0;
		exc_pend_req <= '0;
		if (kind == 0) m_ctrl = m_ctrl | (32'h1 << act_bit[h]);
		if (kind == 0 && h < 4) m_ctrl = m_ctrl & ~(32'h1 << pend_bit[h]);
		if (kind == 0) m_stat = m_stat | 32'h1;
		if (kind == 1) m_ctrl = m_ctrl & ~(32'h1 << act_bit[h]);
		if (kind == 2) m_ctrl = m_ctrl | (32'h1 << pend_bit[h]);
		if (kind == 2) m_stat = m_stat | 32'h2;
		@(posedge ref_clk);
		compare_all();
	endtask : ev
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		$display("unexpected at %0t: run too long", $time);
		final_report();
	end
	initial begin
		void'($urandom(25011));
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 7; a++) begin
			bus(1'b0, ADDR_PRIO_A + 32'(4 * a), 32'h0, 4'hF);
			check(36'(rd), 36'h0);
		end
		compare_all();
		wr_rd(ADDR_PRIO_A, 32'hFFFFFFFF, 4'hF);
		wr_rd(ADDR_IRQ_MASK, 32'h3, 4'h1);
		for (int h = 0; h < 7; h++) begin
			ev(0, h);
			ev(1, h);
		end
		for (int h = 0; h < 4; h++) begin
			ev(2, h);
			ev(0, h);
		end
		// clock enable low: returns are ignored and every output holds
		@(posedge ref_clk);
		clk_en <= 1'b0;
		exc_return <= '1;
		repeat (2) @(posedge ref_clk);
		clk_en <= 1'b1;
		exc_return <= '0;
		@(posedge ref_clk);
		compare_all();
		// active flags are edited by software here and again by random control-word writes in the loop below
		wr_rd(ADDR_CTRL, 32'hFFFFFFFF, 4'hF);
		wr_rd(ADDR_IRQ_STATUS, 32'h1, 4'h1);
		wr_rd(ADDR_IRQ_STATUS, 32'h2, 4'h1);
		for (int n = 0; n < 80; n++) begin
			wr_rd(ADDR_PRIO_A + 32'(4 * $urandom_range(6, 0)), $urandom, 4'($urandom_range(15, 0)));
			ev($urandom_range(2, 0), $urandom_range(3, 0));
		end
		final_report();
	end
endmodule : tb
`default_nettype wire
